// ### rtl/bsup_pkg.sv
// Purpose: shared constants and types for the board supervisor
// Assumes: 20 MHz core clock
// Notes:   timeouts are top-level parameters; defaults below, except START_CYC whose default is in bsup_top
package bsup_pkg;
    localparam int unsigned CLK_HZ          = 20000000;
    localparam int unsigned TICK_MIN_US     = 1000;
    // least tick period in cycles, clock MHz rounded down
    localparam int unsigned TICK_MIN_CYC    =
        (TICK_MIN_US * (CLK_HZ / 1000000) + 0) ;
    localparam int unsigned TICK_DEF_CYC    = TICK_MIN_CYC;
    localparam int unsigned STALL_DEF_CYC   = 64;
    localparam int unsigned SWDOG_DEF_CYC   = 40000;
    localparam int unsigned IRQ_ACK_DEF_CYC = 256;
    localparam int unsigned BLINK_DEF_CYC   = 5000000;
    localparam int unsigned RESET_CYC       = 16;
    localparam int unsigned NUM_BIN         = 8;
    localparam logic [6:0]  SEG_DASH        = 7'h40;
    localparam logic [3:0]  ERR_STALL       = 4'h1;
    localparam logic [3:0]  ERR_UNUSED      = 4'h2;
    localparam logic [3:0]  ERR_SWDOG       = 4'h3;
    localparam logic [3:0]  ERR_IRQC        = 4'h4;
    localparam logic [3:0]  ERR_CPU         = 4'h5;

    typedef enum logic [1:0] {
        BSUP_START,
        BSUP_RUN,
        BSUP_FAULT,
        BSUP_DEAD
    } bsup_mode_e;

    // hex digit to segments g..a
    function automatic logic [6:0] bsup_seg(input logic [3:0] d);
        logic [6:0] s;
        s = 7'h00;
        unique case (d)
            4'h0: s = 7'h3f;  4'h1: s = 7'h06;  4'h2: s = 7'h5b;
            4'h3: s = 7'h4f;  4'h4: s = 7'h66;  4'h5: s = 7'h6d;
            4'h6: s = 7'h7d;  4'h7: s = 7'h07;  4'h8: s = 7'h7f;
            4'h9: s = 7'h6f;  4'ha: s = 7'h77;  4'hb: s = 7'h7c;
            4'hc: s = 7'h39;  4'hd: s = 7'h5e;  4'he: s = 7'h79;
            4'hf: s = 7'h71;
        endcase
        return s;
    endfunction
endpackage

// ### rtl/bsup_bin_if.sv
// Purpose: carrier between the supervisor and its binary input stage
// Assumes: one clock domain
// Notes:   none
`timescale 1ns/1ps
interface bsup_bin_if;
    logic [7:0] level;
    logic [7:0] edge_seen;
    modport stage (output level, output edge_seen);
    modport sup   (input  level, input  edge_seen);
endinterface

// ### rtl/bsup_bin_stage.sv
// Purpose: synchronise eight binary inputs and flag their edges
// Assumes: raw pins are asynchronous to core_clk
// Notes:   edges are taken from the second and third stages
`timescale 1ns/1ps
module bsup_bin_stage
    import bsup_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    input  wire logic [7:0] pin,
    bsup_bin_if.stage       bin
);
    typedef struct packed {
        logic [7:0] s1;
        logic [7:0] s2;
        logic [7:0] s3;
    } bsup_stg_s;

    bsup_stg_s st;
    bsup_stg_s next_st;

    always_comb
    begin
        next_st    = st;
        next_st.s1 = pin;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            st <= '0;
        else
            st <= next_st;
    end

    assign bin.level     = st.s2;
    assign bin.edge_seen = st.s2 ^ st.s3;
endmodule

// ### rtl/bsup_top.sv
// Purpose: board supervisor: watchdogs, nmi, display, event irq, tick
// Assumes: cpu bus signals and soft strobes are on core_clk
// Notes:   key and reset contacts are raw pins and are synchronised
// Contract
// [RULE_01] eight binary inputs, plain or interrupt
// [RULE_02] edge on enabled input requests event job
// [RULE_03] flag error on address stall timeout
// [RULE_04] flag error on access to unused address
// [RULE_05] flag error when software stops retriggering
// [RULE_06] flag error on stuck interrupt controller
// [RULE_07] any monitor error raises nmi
// [RULE_08] cpu fault: inactive, red dot, system error; cpu_fault is ignored in BSUP_START
// [RULE_09] three independent watchdog monitors
// [RULE_10] normal display shows processor id
// [RULE_11] fault shows flashing error code
// [RULE_12] start-up shows a single dash
// [RULE_13] key during error code starts hex monitor
// [RULE_14] bridged reset contacts force full reset
// [RULE_15] periodic tick, configurable, at least 1ms
// [RULE_16] timeouts and unused map are parameters
`timescale 1ns/1ps
module bsup_top
    import bsup_pkg::*;
#(
    parameter int unsigned STALL_CYC   = STALL_DEF_CYC, // [RULE_16]
    parameter int unsigned SWDOG_CYC   = SWDOG_DEF_CYC,
    parameter int unsigned IRQ_ACK_CYC = IRQ_ACK_DEF_CYC,
    parameter int unsigned TICK_CYC    = TICK_DEF_CYC,
    parameter int unsigned BLINK_CYC   = BLINK_DEF_CYC,
    parameter int unsigned START_CYC   = 1024,
    parameter logic [19:0] USED_MASK   = 20'hf0000,
    parameter logic [19:0] USED_LO     = 20'h00000,
    parameter logic [19:0] USED_HI     = 20'hf0000
)
(
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    input  wire logic [19:0] cpu_addr,
    input  wire logic       cpu_addr_valid,
    input  wire logic       sw_retrigger,
    input  wire logic       irq_ack,
    input  wire logic       cpu_fault,
    input  wire logic       start_done,
    input  wire logic [3:0] proc_id,
    input  wire logic [7:0] bin_irq_en,
    input  wire logic [7:0] binary_input_connector,
    input  wire logic       fault_view_key,
    input  wire logic       reset_contact_a,
    input  wire logic       reset_contact_b,
    output logic [7:0]      bin_level,
    output logic [7:0]      event_pending,
    output logic            event_irq,
    output logic            tick_irq,
    output logic            nmi,
    output logic [3:0]      err_code,
    output logic            board_active,
    output logic            sys_error,
    output logic [6:0]      status_display,
    output logic            status_dot,
    output logic            hex_monitor,
    output logic            board_reset
);
    localparam int unsigned TICK_USE =
        (TICK_CYC < TICK_MIN_CYC) ? TICK_MIN_CYC : TICK_CYC;

    typedef struct packed {
        bsup_mode_e mode;
        logic [2:0]  key_sy;
        logic [1:0]  ca_sy;
        logic [1:0]  cb_sy;
        logic [4:0]  rst_cnt;
        logic [31:0] start_cnt;
        logic [31:0] stall_cnt;
        logic [31:0] swd_cnt;
        logic [31:0] ack_cnt;
        logic [31:0] tick_cnt;
        logic [31:0] blink_cnt;
        logic        blink;
        logic [7:0]  pend;
        logic        tick;
        logic        nmi;
        logic [3:0]  err;
        logic        hexmon;
        logic [6:0]  seg;
        logic        dot;
    } bsup_top_s;

    bsup_top_s st;
    bsup_top_s next_st;
    bsup_bin_if bin ();

    bsup_bin_stage u_stage (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .pin      (binary_input_connector),
        .bin      (bin)
    );

    function automatic logic addr_used(input logic [19:0] a);
        logic [19:0] m;
        m = a & USED_MASK;
        return (m >= USED_LO) && (m <= USED_HI);
    endfunction

    logic bridged;
    logic key_rise;
    logic err_stall;
    logic err_unused;
    logic err_swd;
    logic err_irqc;
    logic any_err;

    always_comb
    begin
        bridged   = st.ca_sy[1] & st.cb_sy[1];
        key_rise  = st.key_sy[1] & ~st.key_sy[2];
        err_stall = (st.mode == BSUP_RUN) &&
                    (st.stall_cnt >= STALL_CYC - 1) &&
                    !cpu_addr_valid;                        // [RULE_03]
        err_unused = (st.mode == BSUP_RUN) && cpu_addr_valid &&
                     !addr_used(cpu_addr);                  // [RULE_04]
        err_swd   = (st.mode == BSUP_RUN) &&
                    (st.swd_cnt >= SWDOG_CYC - 1) &&
                    !sw_retrigger;                          // [RULE_05]
        err_irqc  = (st.mode == BSUP_RUN) && (st.pend != 8'h00) &&
                    (st.ack_cnt >= IRQ_ACK_CYC - 1) &&
                    !irq_ack;                               // [RULE_06]
        any_err   = err_stall | err_unused | err_swd | err_irqc; // [RULE_09]
    end

    always_comb
    begin
        next_st        = st;
        next_st.key_sy = {st.key_sy[1:0], fault_view_key};
        next_st.ca_sy  = {st.ca_sy[0], reset_contact_a};
        next_st.cb_sy  = {st.cb_sy[0], reset_contact_b};
        next_st.tick   = 1'b0;

        // hold the forced reset while bridged and a fixed time after, then restart from scratch
        if (bridged)
            next_st.rst_cnt = 5'(RESET_CYC);                // [RULE_14]
        else if (st.rst_cnt != 5'h00)
            next_st.rst_cnt = st.rst_cnt - 5'h01;

        if (st.blink_cnt >= BLINK_CYC - 1)
        begin
            next_st.blink_cnt = '0;
            next_st.blink     = ~st.blink;
        end
        else
            next_st.blink_cnt = st.blink_cnt + 32'h1;

        if (st.tick_cnt >= TICK_USE - 1)
        begin
            next_st.tick_cnt = '0;
            next_st.tick     = 1'b1;                        // [RULE_15]
        end
        else
            next_st.tick_cnt = st.tick_cnt + 32'h1;

        // set wins over acknowledge for a simultaneous edge
        next_st.pend = (irq_ack ? 8'h00 : st.pend) |
                       (bin.edge_seen & bin_irq_en);        // [RULE_01] [RULE_02]
        if (irq_ack || st.pend == 8'h00)
            next_st.ack_cnt = '0;
        else
            next_st.ack_cnt = st.ack_cnt + 32'h1;

        next_st.stall_cnt = cpu_addr_valid ? '0 : st.stall_cnt + 32'h1;
        next_st.swd_cnt   = sw_retrigger ? '0 : st.swd_cnt + 32'h1;

        unique case (st.mode)
            BSUP_START:
            begin
                next_st.start_cnt = st.start_cnt + 32'h1;
                if (start_done || st.start_cnt >= START_CYC - 1)
                    next_st.mode = BSUP_RUN;
            end
            BSUP_RUN:
            begin
                if (cpu_fault)
                begin
                    next_st.mode = BSUP_DEAD;               // [RULE_08]
                    next_st.err  = ERR_CPU;
                end
                else if (any_err)
                begin
                    next_st.mode = BSUP_FAULT;
                    next_st.nmi  = 1'b1;                    // [RULE_07]
                    next_st.err  = err_stall  ? ERR_STALL  :
                                   err_unused ? ERR_UNUSED :
                                   err_swd    ? ERR_SWDOG  : ERR_IRQC;
                end
            end
            BSUP_FAULT:
            begin
                // recovery: software retrigger clears the nmi
                if (cpu_fault)
                begin
                    next_st.mode = BSUP_DEAD;               // [RULE_08]
                    next_st.err  = ERR_CPU;
                end
                else if (sw_retrigger)
                begin
                    next_st.mode      = BSUP_RUN;
                    next_st.nmi       = 1'b0;
                    next_st.stall_cnt = '0;
                end
            end
            BSUP_DEAD:
                next_st.nmi = 1'b0;
        endcase

        if ((st.mode == BSUP_FAULT || st.mode == BSUP_DEAD) && key_rise)
            next_st.hexmon = 1'b1;                          // [RULE_13]

        unique case (st.mode)
            BSUP_START: next_st.seg = SEG_DASH;             // [RULE_12]
            BSUP_RUN:   next_st.seg = bsup_seg(proc_id);    // [RULE_10]
            default:    next_st.seg = st.blink ? bsup_seg(st.err)
                                               : 7'h00;     // [RULE_11]
        endcase
        next_st.dot = (st.mode == BSUP_DEAD);               // [RULE_08]
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst || st.rst_cnt == 5'h01)
        begin
            st        <= '0;
            st.mode   <= BSUP_START;
            st.seg    <= SEG_DASH;
        end
        else
            st <= next_st;
    end

    assign bin_level      = bin.level;
    assign event_pending  = st.pend;
    assign event_irq      = (st.pend != 8'h00);
    assign tick_irq       = st.tick;
    assign nmi            = st.nmi;
    assign err_code       = st.err;
    assign board_active   = (st.mode != BSUP_DEAD);
    assign sys_error      = (st.mode == BSUP_DEAD);
    assign status_display = st.seg;
    assign status_dot     = st.dot;
    assign hex_monitor    = st.hexmon;
    assign board_reset    = (st.rst_cnt != 5'h00);
endmodule

// ### tb/bsup_asserts.sv
// Purpose: port-level assertions for the board supervisor
// Assumes: one clock domain, synchronous active-high reset
// Notes:   stall and tick figures follow the bound parameters
`timescale 1ns/1ps
module bsup_asserts
    import bsup_pkg::*;
#(
    parameter int unsigned STALL_CYC = 64,
    parameter int unsigned TICK_CYC  = 20000
)
(
    input wire logic       core_clk,
    input wire logic       sys_rst,
    input wire logic       cpu_addr_valid,
    input wire logic       sw_retrigger,
    input wire logic [7:0] bin_irq_en,
    input wire logic [7:0] bin_level,
    input wire logic       event_irq,
    input wire logic       tick_irq,
    input wire logic       nmi,
    input wire logic [3:0] err_code,
    input wire logic       board_active,
    input wire logic       sys_error,
    input wire logic [6:0] status_display,
    input wire logic       status_dot,
    input wire logic       hex_monitor,
    input wire logic       board_reset
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);
    int unsigned idle;
    int unsigned gap;
    logic        seen_tick;
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            idle      <= 0;
            gap       <= 0;
            seen_tick <= 1'b0;
        end
        else
        begin
            idle      <= cpu_addr_valid ? 0 : idle + 1;
            gap       <= tick_irq ? 1 : gap + 1;
            // a forced reset restarts the tick divider, so drop history
            seen_tick <= (seen_tick | tick_irq) & !board_reset;
        end
    end
    AST_START: assert property (
        $fell(sys_rst) |-> status_display == SEG_DASH && board_active)
        else $error("display not a dash after reset");
    AST_NMI_CAUSE: assert property (
        $rose(nmi) |-> err_code != 4'h0)
        else $error("nmi raised without an error code");
    AST_NMI_HOLD: assert property (
        nmi && !sw_retrigger && !$past(sw_retrigger) && !board_reset |=> nmi)
        else $error("nmi dropped without a retrigger");
    AST_STALL: assert property (
        $rose(nmi) && err_code == ERR_STALL |-> idle >= STALL_CYC)
        else $error("stall flagged too early");
    AST_UNUSED: assert property (
        $rose(nmi) && err_code == ERR_UNUSED
        |-> $past(cpu_addr_valid) || $past(cpu_addr_valid, 2))
        else $error("unused access flagged without an access");
    AST_DEAD: assert property (
        // the dot register follows the mode one cycle later
        sys_error |-> !board_active && (status_dot || !$past(sys_error)))
        else $error("system error without inactive board and dot");
    AST_DEAD_HOLD: assert property (
        sys_error && !board_reset |=> sys_error)
        else $error("dead state left without reset");
    AST_EVENT: assert property (
        |(bin_level & ~$past(bin_level) & bin_irq_en) |=> event_irq)
        else $error("enabled edge gave no event request");
    AST_TICK: assert property (
        tick_irq && seen_tick |-> gap == TICK_CYC)
        else $error("tick period wrong");
    AST_HEXMON: assert property (
        $rose(hex_monitor) |-> err_code != 4'h0)
        else $error("hex monitor started without an error code");
    AST_FORCED: assert property (
        $rose(board_reset) |-> board_reset [*8] ##[6:12] !board_reset)
        else $error("forced reset length wrong");
endmodule
bind bsup_top bsup_asserts #(
    .STALL_CYC(STALL_CYC),
    .TICK_CYC (TICK_CYC)
) bsup_asserts_i (
    .core_clk, .sys_rst, .cpu_addr_valid, .sw_retrigger, .bin_irq_en,
    .bin_level, .event_irq, .tick_irq, .nmi, .err_code, .board_active,
    .sys_error, .status_display, .status_dot, .hex_monitor, .board_reset
);

// ### tb/bsup_cpu_model.sv
// Purpose: processor bus side seen by the supervisor
// Assumes: changes just after the rising edge
// Notes:   retrigger every 16 cycles while kicking is allowed
`timescale 1ns/1ps
module bsup_cpu_model
(
    input  wire logic        core_clk,
    input  wire logic        go,
    input  wire logic        bad,
    input  wire logic        kick_en,
    input  wire logic        ack_en,
    input  wire logic        event_irq,
    output logic [19:0]      cpu_addr,
    output logic             cpu_addr_valid,
    output logic             sw_retrigger,
    output logic             irq_ack
);
    logic [3:0] cyc = 4'h0;
    initial
    begin
        cpu_addr       = 20'h00000;
        cpu_addr_valid = 1'b0;
        sw_retrigger   = 1'b0;
        irq_ack        = 1'b0;
    end
    always @(posedge core_clk)
    begin
        cyc            <= cyc + 4'h1;
        cpu_addr_valid <= go;
        // idle bus shows a changing value, not the last address
        cpu_addr       <= !go ? ~cpu_addr : bad ? 20'h9a5c3 : {8'h01, cyc, 8'h00};
        sw_retrigger   <= kick_en && cyc == 4'h0;
        // ack_en low models a slow or stuck handler
        irq_ack        <= ack_en && event_irq && !irq_ack;
    end
endmodule

// ### tb/tb_top.sv
// Purpose: self-checking bench for the board supervisor
// Assumes: inputs change on the falling edge
// Notes:   watchdog and blink counts shortened through parameters; tick and start-up counts kept
`timescale 1ns/1ps
module tb_top
    import bsup_pkg::*;
();
    localparam logic [6:0] SEG [16] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66,
        7'h6d, 7'h7d, 7'h07, 7'h7f, 7'h6f, 7'h77, 7'h7c, 7'h39, 7'h5e, 7'h79,
        7'h71};
    string NAMES [9] = '{"display", "state", "pending", "level", "hexmon",
        "board_reset", "flash", "ticks", "dead"};
    logic core_clk = 0, sys_rst = 1, cpu_fault = 0, start_done = 0;
    logic fault_view_key = 0, reset_contact_a = 0, reset_contact_b = 0;
    logic go = 1, bad = 0, kick_en = 1, ack_en = 1, flash_ok = 0;
    logic [3:0] proc_id = 0;
    logic [7:0] bin_irq_en = 0, binary_input_connector = 0, tick_cnt = 0;
    logic [7:0] tick_base = 0;
    logic [31:0] rng = 32'd47;
    logic [19:0] cpu_addr;
    logic cpu_addr_valid, sw_retrigger, irq_ack, event_irq, tick_irq, nmi;
    logic board_active, sys_error, status_dot, hex_monitor, board_reset;
    logic [7:0] bin_level, event_pending, exp_q[$];
    logic [3:0] err_code;
    logic [6:0] status_display;
    int id_q[$], err_total = 0, cmp_count = 0, lit = 0, dark = 0;
    event chk;
    bsup_top #(.STALL_CYC(20), .SWDOG_CYC(50), .IRQ_ACK_CYC(24),
        .BLINK_CYC(4), .USED_HI(20'h70000))
    bsup_top_i (.core_clk, .sys_rst, .cpu_addr, .cpu_addr_valid,
        .sw_retrigger, .irq_ack, .cpu_fault, .start_done, .proc_id,
        .bin_irq_en, .binary_input_connector, .fault_view_key,
        .reset_contact_a, .reset_contact_b, .bin_level, .event_pending,
        .event_irq, .tick_irq, .nmi, .err_code, .board_active, .sys_error,
        .status_display, .status_dot, .hex_monitor, .board_reset);
    bsup_cpu_model bsup_cpu_model_i (.core_clk, .go, .bad, .kick_en, .ack_en,
        .event_irq, .cpu_addr, .cpu_addr_valid, .sw_retrigger, .irq_ack);
    always #25 core_clk = ~core_clk;
    always @(posedge core_clk)
        if (tick_irq === 1'b1)
            tick_cnt <= tick_cnt + 8'h01;
    // ==========================================================
    // helpers
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    function automatic logic [7:0] seen(input int id);
        case (id)
            0: return {1'b0, status_display};
            1: return {board_active, sys_error, status_dot, nmi, err_code};
            2: return event_pending;
            3: return bin_level;
            4: return {7'h00, hex_monitor};
            5: return {7'h00, board_reset};
            6: return {7'h00, flash_ok};
            7: return tick_cnt - tick_base;
            default: return {5'h00, board_active, sys_error, status_dot};
        endcase
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic want(input int id, input logic [7:0] v);
        id_q.push_back(id);
        exp_q.push_back(v);
        -> chk;
        #1;
    endtask
    // stop kicking right after a fresh retrigger
    task automatic quiet();
        @(posedge sw_retrigger);
        @(negedge core_clk);
        kick_en = 0;
    endtask
    task automatic press();
        fault_view_key = 1;
        cyc(4);
        fault_view_key = 0;
        cyc(4);
    endtask
    // the error code is kept after recovery for the hex monitor
    task automatic recover(input logic [3:0] e);
        kick_en = 1;
        cyc(20);
        want(1, {4'b1000, e});
    endtask
    task automatic stop_test();
        if (err_total == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(chk)
    begin
        int id;
        logic [7:0] e;
        id = id_q.pop_front();
        e = exp_q.pop_front();
        cmp_count++;
        if (seen(id) !== e)
        begin
            err_total++;
            $display("FAIL %s expected %h seen %h", NAMES[id], e, seen(id));
        end
    end
    // ==========================================================
    // watchdog
    initial
    begin
        #2500000;
        err_total++;
        stop_test();
    end
    // ==========================================================
    // scenarios
    initial
    begin
        cyc(2);
        sys_rst = 0;
        want(0, {1'b0, SEG_DASH});
        want(1, 8'h80);
        press();
        want(4, 8'h00);
        rng = xs(rng);
        proc_id = rng[3:0];
        start_done = 1;
        cyc(1);
        start_done = 0;
        cyc(12);
        want(0, {1'b0, SEG[proc_id]});
        rng = xs(rng);
        bin_irq_en = rng[7:0];
        binary_input_connector = rng[15:8];
        ack_en = 0;
        cyc(4);
        want(3, rng[15:8]);
        want(2, rng[15:8] & rng[7:0]);
        ack_en = 1;
        cyc(4);
        want(2, 8'h00);
        binary_input_connector = 0;
        cyc(6);
        quiet();
        bad = 1;
        cyc(1);
        bad = 0;
        cyc(3);
        want(1, {4'b1001, ERR_UNUSED});
        repeat (16)
        begin
            @(negedge core_clk);
            if (status_display === SEG[ERR_UNUSED])
                lit++;
            else
                dark++;
        end
        flash_ok = lit > 0 && dark > 0;
        want(6, 8'h01);
        press();
        want(4, 8'h01);
        recover(ERR_UNUSED);
        quiet();
        go = 0;
        cyc(26);
        want(1, {4'b1001, ERR_STALL});
        go = 1;
        recover(ERR_STALL);
        quiet();
        cyc(56);
        want(1, {4'b1001, ERR_SWDOG});
        recover(ERR_SWDOG);
        bin_irq_en = 8'hff;
        ack_en = 0;
        quiet();
        binary_input_connector = 8'h01;
        cyc(32);
        want(1, {4'b1001, ERR_IRQC});
        ack_en = 1;
        cyc(2);
        binary_input_connector = 0;
        recover(ERR_IRQC);
        tick_base = tick_cnt;
        cyc(40000);
        want(7, 8'h02);
        cpu_fault = 1;
        cyc(3);
        want(8, 8'h03);
        cpu_fault = 0;
        reset_contact_a = 1;
        cyc(10);
        want(8, 8'h03);
        want(5, 8'h00);
        reset_contact_b = 1;
        cyc(3);
        reset_contact_a = 0;
        reset_contact_b = 0;
        cyc(1);
        want(5, 8'h01);
        while (board_reset === 1'b1)
            cyc(1);
        want(0, {1'b0, SEG_DASH});
        want(8, 8'h04);
        want(4, 8'h00);
        // no done strobe now: start-up must end by its own timeout
        cyc(1030);
        want(0, {1'b0, SEG[proc_id]});
        stop_test();
    end
endmodule
